// file: src/sfsq_sequencer.sv
// Purpose: soft-start ramp, fault latches and over-current sequencing of a multiphase controller
// Assumes: analog comparators outside deliver enable, bias and fault levels as logic pins
// Notes:   the soft-start level is a digital up/down value in microvolt units

`timescale 1ns/100ps

module sfsq_sequencer
	import sfsq_pkg::*;
(
	input  wire logic                         CLOCK,
	input  wire logic                         SRST,
	input  wire logic [CODE_W-1:0]            SUPPLY_CODE,
	input  wire logic [1:0]                   CODE_MODE_SELECT,
	input  wire logic                         ENABLE_OK,
	input  wire logic                         BIAS_ABOVE_94,
	input  wire logic                         BIAS_BELOW_86,
	input  wire logic                         OUTPUT_IN_REGULATION,
	input  wire logic                         SWITCH_TICK,
	input  wire logic [1:0]                   OSCILLATOR_RESISTOR_SETTING,
	input  wire logic                         OVERVOLTAGE,
	input  wire logic                         OPEN_SENSE,
	input  wire logic                         OPEN_LOOP,
	input  wire logic                         OPEN_CHAIN,
	input  wire logic [SENSE_W-1:0]           CURRENT_SENSE_LEVEL,
	input  wire logic [SENSE_W-1:0]           OVERCURRENT_THRESHOLD,
	output logic      [LVL_W-1:0]             SOFT_START_LEVEL,
	output logic      [LVL_W-1:0]             SETPOINT_DAC_OUTPUT,
	output logic      [LVL_W-1:0]             REGULATION_TARGET,
	output logic                              ERROR_AMP_CLAMP,
	output logic                              PHASE_INHIBIT,
	output logic                              REGULATION_OK,
	output logic                              FAULT_LATCH,
	output logic      [NPERS-1:0]             PERSIST_LATCH,
	output logic                              CODE_FAULT_HOLD,
	output logic                              OC_LIMIT_ACTIVE,
	output logic                              SOFT_START_DONE
);

	import sfsq_pkg::*;

	localparam int PIN_W = 13 + CODE_W + 2 * SENSE_W;

	logic [PIN_W-1:0]   pins;
	logic [PIN_W-1:0]   meta_q;
	logic [PIN_W-1:0]   sync_q;
	logic               enable_s;
	logic               bias_hi_s;
	logic               bias_lo_s;
	logic               in_reg_s;
	logic               tick_s;
	logic [1:0]         osc_s;
	logic [1:0]         mode_s;
	logic [NPERS-1:0]   pers_src_s;
	logic [CODE_W-1:0]  code_s;
	logic [SENSE_W-1:0] sense_s;
	logic [SENSE_W-1:0] thr_s;

	sfsq_mode_t         mode;
	sfsq_state_t        state_q;
	sfsq_lvl_t          level_q;
	sfsq_lvl_t          level_d;
	sfsq_lvl_t          code_uv;
	sfsq_lvl_t          floor_uv;
	sfsq_lvl_t          oc_step;
	sfsq_lvl_t          excess_uv;
	sfsq_lvl_t          ramp_uv;
	sfsq_lvl_t          cap_uv;
	logic [SENSE_W-1:0] excess;
	logic [DLY_W-1:0]   dly_q;
	logic [DLY_W-1:0]   dly_limit;
	logic               bias_ok_q;
	logic               tick_prev_q;
	logic               tick_pulse;
	logic               codes_en_q;
	logic               boot;
	logic               code_active;
	logic               code_fault;
	logic               hold_q;
	logic [NPERS-1:0]   pers_q;
	logic               any_pers;
	logic               fault_q;
	logic               inhibit;
	logic               started_q;
	logic               oc;
	logic               oc_pre;
	logic               oc_post;
	logic               oc_fault;
	logic               fault_set;

	// every pin passes two flip-flops before use
	assign pins = {ENABLE_OK, BIAS_ABOVE_94, BIAS_BELOW_86, OUTPUT_IN_REGULATION, SWITCH_TICK,
		OSCILLATOR_RESISTOR_SETTING, CODE_MODE_SELECT, OVERVOLTAGE, OPEN_SENSE, OPEN_LOOP, OPEN_CHAIN,
		SUPPLY_CODE, CURRENT_SENSE_LEVEL, OVERCURRENT_THRESHOLD};

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	// unpack synchronised pins
	assign {enable_s, bias_hi_s, bias_lo_s, in_reg_s, tick_s, osc_s, mode_s, pers_src_s,
		code_s, sense_s, thr_s} = sync_q;

	assign mode = sfsq_mode_t'(mode_s);
	assign boot = (mode == MODE_BOOT);

	// bias supply window with hysteresis between the two thresholds
	always_ff @(posedge CLOCK) begin
		if (SRST || bias_lo_s) begin
			bias_ok_q <= 1'b0;
		end else if (bias_hi_s) begin
			bias_ok_q <= 1'b1;
		end
	end

	// switching cycle edge for the delay counter
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			tick_prev_q <= 1'b0;
		end else begin
			tick_prev_q <= tick_s;
		end
	end

	assign tick_pulse = tick_s && !tick_prev_q;

	// boot flavour ignores the code until the level passes 3.0 V
	always_ff @(posedge CLOCK) begin
		if (SRST || state_q == ST_HALT) begin
			codes_en_q <= 1'b0;
		end else if (level_q > LVL_CODES) begin
			codes_en_q <= 1'b1;
		end
	end

	assign code_active = !boot || codes_en_q;

	sfsq_code_qual u_code (
		.clk         (CLOCK),
		.srst        (SRST),
		.code        (code_s),
		.code_active (code_active),
		.code_uv     (code_uv),
		.fault_q     (code_fault)
	);

	// boot-flavour code fault sticks until the bias supply is cycled; set wins
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			hold_q <= 1'b0;
		end else if (boot && code_fault) begin
			hold_q <= 1'b1;
		end else if (bias_lo_s) begin
			hold_q <= 1'b0;
		end
	end

	// over-voltage, open sense, open loop and open chain latches, cleared only by bias loss
	generate
		for (genvar i = 0; i < NPERS; i++) begin : g_pers
			always_ff @(posedge CLOCK) begin
				if (SRST) begin
					pers_q[i] <= 1'b0;
				end else if (pers_src_s[i]) begin
					pers_q[i] <= 1'b1;
				end else if (bias_lo_s) begin
					pers_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign any_pers = |pers_q;

	// over-current comparison and its split before and after power-good
	assign oc      = sense_s > thr_s;
	assign excess  = oc ? sense_s - thr_s : '0;
	assign oc_pre  = oc && !started_q && (state_q == ST_RAMP);
	assign oc_post = oc && started_q;

	// delay length chosen by the oscillator setting
	always_comb begin
		case (osc_s)
			2'h0:    dly_limit = OC_DLY_0;
			2'h1:    dly_limit = OC_DLY_1;
			2'h2:    dly_limit = OC_DLY_2;
			default: dly_limit = OC_DLY_3;
		endcase
	end

	// soft-start over-current delay counts switching cycles while over-current stands
	always_ff @(posedge CLOCK) begin
		if (SRST || !oc_pre) begin
			dly_q <= '0;
		end else if (tick_pulse && dly_q < dly_limit) begin
			dly_q <= dly_q + 10'h001;
		end
	end

	assign oc_fault = (oc_pre && dly_q >= dly_limit)
		|| (oc_post && level_q < LVL_OC_TRIP);
	assign fault_set = !bias_ok_q || code_fault || hold_q || !enable_s || oc_fault;

	// resettable fault latch: starts set, released at the restart point once causes clear
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			fault_q <= 1'b1;
		end else if (fault_set) begin
			fault_q <= 1'b1;
		end else if (level_q <= LVL_FLOOR && !any_pers) begin
			fault_q <= 1'b0;
		end
	end

	assign inhibit = fault_q || any_pers;

	// sequencer state
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			state_q <= ST_HALT;
		end else if (inhibit) begin
			state_q <= ST_HALT;
		end else begin
			case (state_q)
				ST_HALT: state_q <= ST_RAMP;
				ST_RAMP: if (level_q >= LVL_FINAL) begin
					state_q <= ST_RUN;
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// power-good has been reached in this start; keeps post-start handling through the delay
	always_ff @(posedge CLOCK) begin
		if (SRST || inhibit) begin
			started_q <= 1'b0;
		end else if (level_q > LVL_REGULATION_OK) begin
			started_q <= 1'b1;
		end
	end

	// level steps: fault discharge, over-current regulation or discharge, else charge
	assign floor_uv  = any_pers ? LVL_ZERO : LVL_FLOOR;
	assign excess_uv = LVL_W'(excess) * OC_GAIN;
	assign oc_step   = (excess_uv > OC_MAX_STEP) ? OC_MAX_STEP : excess_uv;

	always_comb begin
		level_d = level_q;
		if (inhibit) begin
			if (level_q > floor_uv) begin
				level_d = (level_q - floor_uv > DISCH_STEP) ? level_q - DISCH_STEP : floor_uv;
			end
		end else if (oc_post) begin
			level_d = (level_q > oc_step) ? level_q - oc_step : LVL_ZERO;
		end else if (oc_pre) begin
			if (level_q > LVL_FLOOR) begin
				level_d = (level_q - LVL_FLOOR > DISCH_STEP) ? level_q - DISCH_STEP : LVL_FLOOR;
			end
		end else if (state_q != ST_HALT) begin
			level_d = (LVL_FINAL - level_q > CHARGE_STEP) ? level_q + CHARGE_STEP : LVL_FINAL;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			level_q <= LVL_ZERO;
		end else begin
			level_q <= level_d;
		end
	end

	// regulation target follows the level less the clamp offset, capped at the code setpoint, or at the boot level while codes are inactive
	assign ramp_uv = (level_q > LVL_CLAMP) ? level_q - LVL_CLAMP : LVL_ZERO;
	assign cap_uv  = code_active ? code_uv : BOOT_UV;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			REGULATION_TARGET   <= LVL_ZERO;
			SETPOINT_DAC_OUTPUT <= BOOT_UV + PREPOS_UV;
		end else begin
			REGULATION_TARGET   <= (ramp_uv < cap_uv) ? ramp_uv : cap_uv;
			SETPOINT_DAC_OUTPUT <= cap_uv + PREPOS_UV;
		end
	end

	// pin-level outputs, all registered
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			SOFT_START_LEVEL <= LVL_ZERO;
			ERROR_AMP_CLAMP  <= 1'b1;
			PHASE_INHIBIT    <= 1'b1;
			REGULATION_OK    <= 1'b0;
			FAULT_LATCH      <= 1'b1;
			PERSIST_LATCH    <= '0;
			CODE_FAULT_HOLD  <= 1'b0;
			OC_LIMIT_ACTIVE  <= 1'b0;
			SOFT_START_DONE  <= 1'b0;
		end else begin
			SOFT_START_LEVEL <= level_q;
			ERROR_AMP_CLAMP  <= inhibit || level_q < LVL_CLAMP;
			PHASE_INHIBIT    <= inhibit;
			REGULATION_OK    <= !inhibit && in_reg_s && (level_q > LVL_REGULATION_OK || started_q);
			FAULT_LATCH      <= fault_q;
			PERSIST_LATCH    <= pers_q;
			CODE_FAULT_HOLD  <= hold_q;
			OC_LIMIT_ACTIVE  <= oc_pre;
			SOFT_START_DONE  <= !inhibit && state_q == ST_RUN;
		end
	end

endmodule : sfsq_sequencer

// file: src/sfsq_pkg.sv
// Purpose: shared constants and types of the soft-start and fault sequencer
// Assumes: levels are held in microvolt units, currents in millivolt sense units
// Notes:   soft-start steps are per clock and keep the ratio of the charge and discharge sources

package sfsq_pkg;

	// widths
	localparam int LVL_W   = 22;
	localparam int CODE_W  = 5;
	localparam int SENSE_W = 12;
	localparam int DLY_W   = 10;
	localparam int QUAL_W  = 8;
	localparam int NPERS   = 4;

	typedef logic [LVL_W-1:0] sfsq_lvl_t;

	// start-up flavours picked by the mode-select input
	typedef enum logic [1:0] {
		MODE_BOOT,
		MODE_STD,
		MODE_5BIT,
		MODE_6BIT
	} sfsq_mode_t;

	// sequencer states
	typedef enum logic [1:0] {
		ST_HALT,
		ST_RAMP,
		ST_RUN
	} sfsq_state_t;

	// soft-start comparator points, microvolts
	localparam sfsq_lvl_t LVL_FLOOR   = 22'h030D40; // 0.2 V restart point
	localparam sfsq_lvl_t LVL_OC_TRIP = 22'h01D4C0; // 120 mV delay comparator offset
	localparam sfsq_lvl_t LVL_CLAMP   = 22'h155CC0; // 1.4 V amplifier release
	localparam sfsq_lvl_t LVL_CODES   = 22'h2DC6C0; // 3.0 V code enable in boot flavour
	localparam sfsq_lvl_t LVL_REGULATION_OK   = 22'h3BD080; // 3.92 V power-good permit
	localparam sfsq_lvl_t LVL_FINAL   = 22'h3D0900; // 4.0 V end of soft start
	localparam sfsq_lvl_t LVL_ZERO    = 22'h000000;

	// setpoint figures, microvolts
	localparam sfsq_lvl_t BOOT_UV     = 22'h10C8E0; // 1.1 V boot level
	localparam sfsq_lvl_t PREPOS_UV   = 22'h00C350; // 50 mV load-line pre-position
	localparam sfsq_lvl_t CODE_TOP_UV = 22'h17A6B0; // 1.550 V at code 0
	localparam sfsq_lvl_t CODE_STEP_UV = 22'h0061A8; // 25 mV per code step
	localparam logic [CODE_W-1:0] CODE_FAULT = 5'h1F;

	// per-clock level steps: 10 units per microamp of source current
	localparam sfsq_lvl_t CHARGE_STEP = 22'h00020D; // 52.5 uA
	localparam sfsq_lvl_t DISCH_STEP  = 22'h000028; // 4 uA
	localparam sfsq_lvl_t OC_MAX_STEP = 22'h000226; // 55 uA cap
	localparam sfsq_lvl_t OC_GAIN     = 22'h00000A; // step per mV of over-current excess

	// fault-code qualification time
	localparam int CLK_PERIOD_NS = 32'h8;   // 8 ns
	localparam int CODE_QUAL_NS  = 32'h514; // 1300 ns
	localparam logic [QUAL_W-1:0] CODE_QUAL_CYC =
		QUAL_W'((CODE_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// soft-start over-current delay in switching cycles, per oscillator setting
	localparam logic [DLY_W-1:0] OC_DLY_0 = 10'h040;
	localparam logic [DLY_W-1:0] OC_DLY_1 = 10'h080;
	localparam logic [DLY_W-1:0] OC_DLY_2 = 10'h100;
	localparam logic [DLY_W-1:0] OC_DLY_3 = 10'h200;

endpackage : sfsq_pkg

// file: src/sfsq_code_qual.sv
// Purpose: decode the 5-bit supply code and qualify the fault code
// Assumes: code arrives already synchronised to the clock
// Notes:   the fault code must stand for the full qualification time before it reports

`timescale 1ns/100ps

module sfsq_code_qual
	import sfsq_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic [CODE_W-1:0]       code,
	input  wire logic                    code_active,
	output logic      [LVL_W-1:0]        code_uv,
	output logic                         fault_q
);

	logic [QUAL_W-1:0] qual_cnt_q;
	logic              is_fault;

	assign is_fault = code_active && (code == CODE_FAULT);

	// setpoint falls 25 mV per code from the top value; fault code keeps the last value
	always_ff @(posedge clk) begin
		if (srst) begin
			code_uv <= CODE_TOP_UV;
		end else if (code != CODE_FAULT) begin
			code_uv <= LVL_W'(CODE_TOP_UV - LVL_W'(code) * CODE_STEP_UV);
		end
	end

	// fault code only counts after it has stood unbroken; passing codes restart the count
	always_ff @(posedge clk) begin
		if (srst || !is_fault) begin
			qual_cnt_q <= '0;
			fault_q    <= 1'b0;
		end else if (qual_cnt_q >= CODE_QUAL_CYC - 8'h01) begin
			fault_q    <= 1'b1;
		end else begin
			qual_cnt_q <= qual_cnt_q + 8'h01;
		end
	end

endmodule : sfsq_code_qual

// file: dv/sfsq_seq_properties.sv
// Purpose: port-level checks of the soft-start and fault sequencer
// Assumes: outputs registered, level output one cycle behind its source
// Notes:   margins of four steps absorb that lag
`timescale 1ns/100ps
module sfsq_seq_properties
	import sfsq_pkg::*;
(
	input wire logic             CLOCK,
	input wire logic             SRST,
	input wire logic             BIAS_BELOW_86,
	input wire logic [LVL_W-1:0] SOFT_START_LEVEL,
	input wire logic [LVL_W-1:0] REGULATION_TARGET,
	input wire logic             ERROR_AMP_CLAMP,
	input wire logic             PHASE_INHIBIT,
	input wire logic             REGULATION_OK,
	input wire logic             FAULT_LATCH,
	input wire logic [NPERS-1:0] PERSIST_LATCH,
	input wire logic             OC_LIMIT_ACTIVE,
	input wire logic             SOFT_START_DONE
);
	localparam sfsq_lvl_t MARG = 22'h000834;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);
	// start-up comparators
	a_clamp_low_level: assert property (
		SOFT_START_LEVEL < LVL_CLAMP - MARG && !SOFT_START_DONE |-> ERROR_AMP_CLAMP) else $error("clamp released low");
	a_target_zero_low: assert property (
		SOFT_START_LEVEL < LVL_CLAMP - MARG && !SOFT_START_DONE |-> REGULATION_TARGET == LVL_ZERO)
		else $error("target not zero below clamp");
	a_regulation_ok_rise_level: assert property (
		$rose(REGULATION_OK) |-> SOFT_START_LEVEL >= LVL_REGULATION_OK - MARG) else $error("power good too early");
	a_done_final_level: assert property (
		$rose(SOFT_START_DONE) |-> ##[0:2] SOFT_START_LEVEL == LVL_FINAL) else $error("done off final level");
	// level slopes
	a_ramp_charge_rate: assert property (
		SOFT_START_LEVEL > $past(SOFT_START_LEVEL) |->
		SOFT_START_LEVEL - $past(SOFT_START_LEVEL) == CHARGE_STEP || SOFT_START_LEVEL == LVL_FINAL)
		else $error("wrong charge step");
	a_fault_disch_rate: assert property (
		FAULT_LATCH && $past(FAULT_LATCH) && $past(FAULT_LATCH, 2) && SOFT_START_LEVEL < $past(SOFT_START_LEVEL)
		|-> $past(SOFT_START_LEVEL) - SOFT_START_LEVEL <= DISCH_STEP) else $error("fault discharge too fast");
	a_oc_step_cap: assert property (
		SOFT_START_LEVEL < $past(SOFT_START_LEVEL) |-> $past(SOFT_START_LEVEL) - SOFT_START_LEVEL <= OC_MAX_STEP)
		else $error("discharge above cap");
	// fault latches
	a_fault_shuts_down: assert property (
		FAULT_LATCH || PERSIST_LATCH != 4'h0 |-> ##[0:2] ERROR_AMP_CLAMP && PHASE_INHIBIT && !REGULATION_OK)
		else $error("fault left output running");
	a_persist_sticky: assert property (
		(!BIAS_BELOW_86) [*5] ##0 PERSIST_LATCH != 4'h0 |=> (PERSIST_LATCH & $past(PERSIST_LATCH)) == $past(PERSIST_LATCH))
		else $error("sticky latch cleared");
	a_persist_no_rise: assert property (
		PERSIST_LATCH != 4'h0 && $past(PERSIST_LATCH, 2) != 4'h0 |-> SOFT_START_LEVEL <= $past(SOFT_START_LEVEL))
		else $error("ramp under sticky latch");
	c_regulation_ok: cover property ($rose(REGULATION_OK));
	c_persist: cover property ($rose(PERSIST_LATCH != 4'h0));
	c_oc_limit: cover property ($rose(OC_LIMIT_ACTIVE));
endmodule : sfsq_seq_properties

bind sfsq_sequencer sfsq_seq_properties i_props (
	.CLOCK(CLOCK), .SRST(SRST), .BIAS_BELOW_86(BIAS_BELOW_86), .SOFT_START_LEVEL(SOFT_START_LEVEL),
	.REGULATION_TARGET(REGULATION_TARGET), .ERROR_AMP_CLAMP(ERROR_AMP_CLAMP), .PHASE_INHIBIT(PHASE_INHIBIT),
	.REGULATION_OK(REGULATION_OK), .FAULT_LATCH(FAULT_LATCH), .PERSIST_LATCH(PERSIST_LATCH),
	.OC_LIMIT_ACTIVE(OC_LIMIT_ACTIVE), .SOFT_START_DONE(SOFT_START_DONE)
);

// file: dv/sfsq_far_side.sv
// Purpose: phase chips and load as seen by the sequencer
// Assumes: phases switch only while nothing inhibits them
// Notes:   sense reads zero while switching is held off
`timescale 1ns/100ps
module sfsq_far_side
	import sfsq_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               clamp,
	input  wire logic               inhibit,
	input  wire logic [SENSE_W-1:0] load_mv,
	output logic                    switch_tick,
	output logic                    in_regulation,
	output logic      [SENSE_W-1:0] sense_mv
);
	logic [2:0] div_q;
	// switching clock at one eighth of the system clock
	always_ff @(negedge clk) begin
		if (srst) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end
	assign switch_tick = div_q[2];
	// output follows the loop only while released
	assign in_regulation = !clamp && !inhibit;
	assign sense_mv = inhibit ? 12'h000 : load_mv;
endmodule : sfsq_far_side

// file: dv/sfsq_sequencer_tb_top.sv
// Purpose: self-checking bench of the soft-start and fault sequencer
// Assumes: far-side model closes the loop from clamp and inhibit
// Notes:   inputs move on the falling clock edge
`timescale 1ns/100ps
module sfsq_sequencer_tb_top;
	import sfsq_pkg::*;
	logic               CLOCK, SRST, ENABLE_OK, BIAS_ABOVE_94, BIAS_BELOW_86, SWITCH_TICK, OUTPUT_IN_REGULATION;
	logic               SOFT_START_DONE, REGULATION_OK, ERROR_AMP_CLAMP, PHASE_INHIBIT, FAULT_LATCH;
	logic               CODE_FAULT_HOLD, OC_LIMIT_ACTIVE;
	logic [CODE_W-1:0]  SUPPLY_CODE;
	logic [1:0]         CODE_MODE_SELECT, OSCILLATOR_RESISTOR_SETTING;
	logic [3:0]         raw_fault, PERSIST_LATCH;
	logic [SENSE_W-1:0] CURRENT_SENSE_LEVEL, OVERCURRENT_THRESHOLD, load_mv;
	sfsq_lvl_t          SOFT_START_LEVEL, SETPOINT_DAC_OUTPUT, REGULATION_TARGET, last_lvl;
	int                 fails, check_count, waited, cyc;
	wire [2:0]          flags = {SOFT_START_DONE, REGULATION_OK, FAULT_LATCH};

	sfsq_sequencer i_dut (.CLOCK(CLOCK), .SRST(SRST), .SUPPLY_CODE(SUPPLY_CODE), .CODE_MODE_SELECT(CODE_MODE_SELECT),
		.ENABLE_OK(ENABLE_OK), .BIAS_ABOVE_94(BIAS_ABOVE_94), .BIAS_BELOW_86(BIAS_BELOW_86),
		.OUTPUT_IN_REGULATION(OUTPUT_IN_REGULATION), .SWITCH_TICK(SWITCH_TICK),
		.OSCILLATOR_RESISTOR_SETTING(OSCILLATOR_RESISTOR_SETTING), .OVERVOLTAGE(raw_fault[3]),
		.OPEN_SENSE(raw_fault[2]), .OPEN_LOOP(raw_fault[1]), .OPEN_CHAIN(raw_fault[0]),
		.CURRENT_SENSE_LEVEL(CURRENT_SENSE_LEVEL), .OVERCURRENT_THRESHOLD(OVERCURRENT_THRESHOLD),
		.SOFT_START_LEVEL(SOFT_START_LEVEL), .SETPOINT_DAC_OUTPUT(SETPOINT_DAC_OUTPUT),
		.REGULATION_TARGET(REGULATION_TARGET), .ERROR_AMP_CLAMP(ERROR_AMP_CLAMP), .PHASE_INHIBIT(PHASE_INHIBIT),
		.REGULATION_OK(REGULATION_OK), .FAULT_LATCH(FAULT_LATCH), .PERSIST_LATCH(PERSIST_LATCH),
		.CODE_FAULT_HOLD(CODE_FAULT_HOLD), .OC_LIMIT_ACTIVE(OC_LIMIT_ACTIVE), .SOFT_START_DONE(SOFT_START_DONE));
	sfsq_far_side i_far (.clk(CLOCK), .srst(SRST), .clamp(ERROR_AMP_CLAMP), .inhibit(PHASE_INHIBIT),
		.load_mv(load_mv), .switch_tick(SWITCH_TICK), .in_regulation(OUTPUT_IN_REGULATION),
		.sense_mv(CURRENT_SENSE_LEVEL));

	// clock and run ceiling
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 70000) begin
			fails++;
			$display("wrong value at %0t ns: run too long", $time);
			give_verdict;
		end
	end

	task automatic check(input sfsq_lvl_t seen, input sfsq_lvl_t want);
		check_count++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge CLOCK);
	endtask : tick
	// bounded wait for a flag: 0 fault, 1 power good, 2 done
	task automatic wait_flag(input int idx, input logic val, input int lim);
		waited = 0;
		while (flags[idx] !== val && waited < lim) begin
			@(negedge CLOCK);
			waited++;
		end
		check(flags[idx], val);
	endtask : wait_flag
	// one-cycle change of the level
	task automatic rate(input sfsq_lvl_t want, input logic down);
		last_lvl = SOFT_START_LEVEL;
		tick(1);
		check(down ? last_lvl - SOFT_START_LEVEL : SOFT_START_LEVEL - last_lvl, want);
	endtask : rate
	task automatic do_reset(input logic [1:0] mode, input logic [CODE_W-1:0] code);
		SRST = 1'b1;
		CODE_MODE_SELECT = mode;
		SUPPLY_CODE = code;
		tick(6);
		SRST = 1'b0;
	endtask : do_reset
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	// test sequence
	initial begin
		ENABLE_OK = 1'b1;
		BIAS_ABOVE_94 = 1'b1;
		BIAS_BELOW_86 = 1'b0;
		OSCILLATOR_RESISTOR_SETTING = 2'h0;
		raw_fault = 4'h0;
		load_mv = 12'h000;
		OVERCURRENT_THRESHOLD = 12'h100;
		do_reset(2'h2, 5'h00);
		wait_flag(0, 1'b0, 40);
		tick(3);
		rate(CHARGE_STEP, 1'b0);
		check(SETPOINT_DAC_OUTPUT, CODE_TOP_UV + PREPOS_UV);
		tick(700);
		SUPPLY_CODE = CODE_FAULT;
		tick(120);
		check(FAULT_LATCH, 1'b0);
		wait_flag(0, 1'b1, 100);
		tick(4);
		check(ERROR_AMP_CLAMP, 1'b1);
		rate(DISCH_STEP, 1'b1);
		SUPPLY_CODE = 5'h00;
		wait_flag(0, 1'b0, 9000);
		check(SOFT_START_LEVEL - LVL_FLOOR < 22'h001000, 1'b1);
		$display("test code fault and restart finished");
		for (int i = 0; i < 4; i++) begin
			raw_fault = 4'h1 << i;
			tick(8);
			raw_fault = 4'h0;
			tick(i == 0 ? 6000 : 40);
			check(PERSIST_LATCH, 4'h1 << i);
			check(i == 0 ? SOFT_START_LEVEL : 22'(PHASE_INHIBIT), i == 0 ? LVL_ZERO : 22'h000001);
			BIAS_BELOW_86 = 1'b1;
			BIAS_ABOVE_94 = 1'b0;
			tick(8);
			check(FAULT_LATCH, 1'b1);
			BIAS_BELOW_86 = 1'b0;
			tick(10);
			check(FAULT_LATCH, 1'b1);
			BIAS_ABOVE_94 = 1'b1;
			wait_flag(0, 1'b0, 40);
			check(PERSIST_LATCH, 4'h0);
		end
		$display("test sticky latches finished");
		load_mv = 12'h180;
		wait_flag(0, 1'b1, 800);
		for (int j = 0; j < 4; j++) begin
			OSCILLATOR_RESISTOR_SETTING = 2'(j);
			wait_flag(0, 1'b0, 400);
			tick(20);
			check(OC_LIMIT_ACTIVE, 1'b1);
			wait_flag(0, 1'b1, 5000);
			check(waited + 20 >= (512 << j) - 16 && waited + 20 <= (512 << j) + 40, 1'b1);
		end
		load_mv = 12'h000;
		$display("test start-up over-current finished");
		wait_flag(0, 1'b0, 400);
		wait_flag(1, 1'b1, 8000);
		check(SOFT_START_LEVEL > LVL_REGULATION_OK, 1'b1);
		wait_flag(2, 1'b1, 400);
		check(SOFT_START_LEVEL, LVL_FINAL);
		check(REGULATION_TARGET, CODE_TOP_UV);
		for (int c = 0; c < 31; c++) begin
			SUPPLY_CODE = 5'(c);
			tick(6);
			check(SETPOINT_DAC_OUTPUT, CODE_TOP_UV + PREPOS_UV - 22'(c) * CODE_STEP_UV);
		end
		check(REGULATION_TARGET, CODE_TOP_UV - 22'h00001E * CODE_STEP_UV);
		load_mv = 12'h114;
		tick(8);
		rate(22'h0000C8, 1'b1);
		check(REGULATION_OK, 1'b1);
		load_mv = 12'h200;
		tick(8);
		rate(OC_MAX_STEP, 1'b1);
		wait_flag(0, 1'b1, 8000);
		check(SOFT_START_LEVEL < LVL_OC_TRIP, 1'b1);
		tick(3);
		check(REGULATION_OK, 1'b0);
		load_mv = 12'h000;
		wait_flag(0, 1'b0, 400);
		$display("test code table and run over-current finished");
		do_reset(2'h0, 5'h04);
		wait_flag(0, 1'b0, 40);
		tick(10);
		check(SETPOINT_DAC_OUTPUT, BOOT_UV + PREPOS_UV);
		wait_flag(1, 1'b1, 8000);
		check(SETPOINT_DAC_OUTPUT, CODE_TOP_UV + PREPOS_UV - 22'h000004 * CODE_STEP_UV);
		SUPPLY_CODE = CODE_FAULT;
		tick(200);
		SUPPLY_CODE = 5'h00;
		tick(100);
		check(CODE_FAULT_HOLD, 1'b1);
		$display("test boot flavour finished");
		give_verdict;
	end
endmodule : sfsq_sequencer_tb_top
